// ---- verilog/dpr_consts.svh ----
// Constants of the DDR4 precharge and refresh core: offsets, fields, resets, timings.
// Assumes inclusion by bare name from the core.
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DPR_REG_CTRL     8'h00
`define DPR_REG_STATUS   8'h04
`define DPR_REG_ROWCNT   8'h08
`define DPR_REG_ERR      8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DPR_CTRL_RMODE_LSB   0
`define DPR_CTRL_TEMPREF_EN  3
`define DPR_CTRL_TEMPREF_EXT 4
`define DPR_CTRL_ZONE_LSB  5
`define DPR_ST_BUSY        0
`define DPR_ST_RATE_LSB    1
`define DPR_ST_RSVD        3
`define DPR_ST_OPEN_LSB    16
`define DPR_ERR_TRFC       0
`define DPR_ERR_ACT        1
`define DPR_ERR_RDWR       2
`define DPR_ERR_REF        3
`define DPR_ERR_MODE       4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define DPR_CTRL_RST     7'h00
`define DPR_ERR_RST      5'h00

// ----------------------------------------
// Mode codes and timing
// ----------------------------------------
`define DPR_RMODE_1X     3'h0
`define DPR_RMODE_2X     3'h1
`define DPR_RMODE_4X     3'h2
`define DPR_RMODE_OTF2   3'h5
`define DPR_RMODE_OTF4   3'h6
`define DPR_CLK_MHZ      50
`define DPR_TRP_NS       14
`define DPR_TRFC1_NS     350
`define DPR_TRFC2_NS     260
`define DPR_TRFC4_NS     160
`define DPR_TRTP_NS      8
`define DPR_TWR_NS       15
`define DPR_WBURST_CYC   16

`endif

// ---- verilog/dpr_pkg.sv ----
// Types shared by the DDR4 precharge and refresh core and its bank tracker.
// Assumes nothing beyond a SystemVerilog compiler.
package dpr_pkg;

  // Sampled command pins
  typedef struct packed {
    logic       cs_n;
    logic       act_n;
    logic       ras_n;
    logic       cas_n;
    logic       we_n;
    logic       a10;
    logic [1:0] bg;
    logic [1:0] ba;
  } dpr_cmd_t;

  typedef enum logic [1:0] {BK_IDLE, BK_OPEN, BK_PRE} dpr_bank_st_t;

  typedef struct packed {
    dpr_bank_st_t st;
    logic [7:0]   cnt;
    logic         ap_pend;
    logic [7:0]   ap_cnt;
  } dpr_bank_t;

  typedef enum logic {RF_IDLE, RF_BUSY} dpr_rf_st_t;

  typedef struct packed {
    logic [1:0] temp_zone;
    logic       tempref_ext;
    logic       tempref_en;
    logic [2:0] rmode;
  } dpr_ctrl_t;

  typedef struct packed {
    dpr_cmd_t    s1;
    dpr_cmd_t    s2;
    dpr_ctrl_t   ctrl;
    logic [4:0]  err;
    dpr_rf_st_t  rf_st;
    logic [9:0]  rf_cnt;
    logic [1:0]  rf_rate;
    logic [15:0] row_ctr;
    logic [15:0] skip_ctr;
    logic [1:0]  gear;
    logic [31:0] prdata;
    logic        pslverr;
  } dpr_core_t;

endpackage

// ---- verilog/dpr_bank.sv ----
// One bank's row state: open, precharging with tRP timing, and auto-precharge hold-off.
// Assumes command strobes already decoded and synchronous to clock.
`timescale 1ns/1ps
module dpr_bank import dpr_pkg::*; #(
  parameter logic [7:0] RP_CYC    = 8'h01,
  parameter logic [7:0] RD_AP_CYC = 8'h01,
  parameter logic [7:0] WR_AP_CYC = 8'h01
) (
  // Clocking
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  // Decoded commands for this bank
  input  wire logic act,
  input  wire logic pre,
  input  wire logic rd,
  input  wire logic wr,
  input  wire logic ap,
  input  wire logic ref_force,
  // State
  output logic      bank_open,
  output logic      bank_idle
);

  dpr_bank_t r;
  dpr_bank_t r_nxt;

  always_comb begin
    r_nxt = r;
    case (r.st)
      BK_IDLE: begin
        if (act) begin
          r_nxt.st = BK_OPEN;
        end
      end
      BK_OPEN: begin
        if (pre) begin
          r_nxt.st      = BK_PRE;
          r_nxt.cnt     = RP_CYC;
          r_nxt.ap_pend = 1'b0;
        end else if (r.ap_pend) begin
          // Hold precharge until restore or last write beat is stored
          if (r.ap_cnt == 8'h00) begin
            r_nxt.st      = BK_PRE;
            r_nxt.cnt     = RP_CYC;
            r_nxt.ap_pend = 1'b0;
          end else begin
            r_nxt.ap_cnt = r.ap_cnt - 8'h01;
          end
        end else if ((rd || wr) && ap) begin
          r_nxt.ap_pend = 1'b1;
          r_nxt.ap_cnt  = wr ? WR_AP_CYC : RD_AP_CYC;
        end
      end
      BK_PRE: begin
        if (pre) begin
          r_nxt.cnt = RP_CYC;
        end else if (r.cnt <= 8'h01) begin
          r_nxt.st = BK_IDLE;
        end else begin
          r_nxt.cnt = r.cnt - 8'h01;
        end
      end
      default: begin
        r_nxt.st = BK_IDLE;
      end
    endcase
    if (ref_force) begin
      r_nxt.st      = BK_IDLE;
      r_nxt.ap_pend = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '{st: BK_IDLE, cnt: 8'h00, ap_pend: 1'b0, ap_cnt: 8'h00};
    end else if (clk_en) begin
      r <= r_nxt;
    end
  end

  assign bank_open = (r.st == BK_OPEN);
  assign bank_idle = (r.st == BK_IDLE);

endmodule

// ---- verilog/dpr_core.sv ----
// DDR4 device-side precharge, auto-precharge and refresh core with an APB register file.
// Assumes command pins arrive asynchronously and are sampled once per command on clock.
`timescale 1ns/1ps
`include "dpr_consts.svh"
module dpr_core import dpr_pkg::*; #(
  parameter int NBANK     = 16,
  parameter int TRP_NS    = `DPR_TRP_NS,
  parameter int TRFC1_NS  = `DPR_TRFC1_NS,
  parameter int TRFC2_NS  = `DPR_TRFC2_NS,
  parameter int TRFC4_NS  = `DPR_TRFC4_NS,
  parameter int TRTP_NS   = `DPR_TRTP_NS,
  parameter int TWR_NS    = `DPR_TWR_NS,
  parameter int WBURST    = `DPR_WBURST_CYC
) (
  // Clocking
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Command pins from the controller
  input  wire dpr_cmd_t          cmd_pins,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Status
  output logic [NBANK-1:0]       bank_open,
  output logic                   refresh_busy,
  output logic [15:0]            refresh_row
);

  // ----------------------------------------
  // Timing counts
  // ----------------------------------------
  localparam int RP_C    = (TRP_NS * `DPR_CLK_MHZ + 999) / 1000;
  localparam int RFC1_C  = (TRFC1_NS * `DPR_CLK_MHZ + 999) / 1000;
  localparam int RFC2_C  = (TRFC2_NS * `DPR_CLK_MHZ + 999) / 1000;
  localparam int RFC4_C  = (TRFC4_NS * `DPR_CLK_MHZ + 999) / 1000;
  localparam int RTP_C   = (TRTP_NS * `DPR_CLK_MHZ + 999) / 1000;
  localparam int WR_C    = (TWR_NS * `DPR_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] RP_CYC    = 8'(RP_C < 1 ? 1 : RP_C);
  localparam logic [7:0] RD_AP_CYC = 8'(RTP_C < 1 ? 1 : RTP_C);
  localparam logic [7:0] WR_AP_CYC = 8'(WBURST + WR_C);
  localparam logic [9:0] RFC1_CYC  = 10'(RFC1_C < 1 ? 1 : RFC1_C);
  localparam logic [9:0] RFC2_CYC  = 10'(RFC2_C < 1 ? 1 : RFC2_C);
  localparam logic [9:0] RFC4_CYC  = 10'(RFC4_C < 1 ? 1 : RFC4_C);

  dpr_core_t r;
  dpr_core_t r_nxt;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic             c_act;
  logic             c_pre;
  logic             c_rd;
  logic             c_wr;
  logic             c_ref;
  logic             c_any;
  logic             take;
  logic [3:0]       bidx;
  logic [NBANK-1:0] bank_idle;
  logic [NBANK-1:0] sel;
  logic             all_idle;
  logic             ref_go;

  always_comb begin
    c_any = !r.s2.cs_n;
    c_act = c_any && !r.s2.act_n;
    c_ref = c_any && r.s2.act_n && !r.s2.ras_n && !r.s2.cas_n && r.s2.we_n;
    c_pre = c_any && r.s2.act_n && !r.s2.ras_n && r.s2.cas_n && !r.s2.we_n;
    c_rd  = c_any && r.s2.act_n && r.s2.ras_n && !r.s2.cas_n && r.s2.we_n;
    c_wr  = c_any && r.s2.act_n && r.s2.ras_n && !r.s2.cas_n && !r.s2.we_n;
    // Commands inside tRFC are dropped rather than corrupting bank state
    take  = (r.rf_st == RF_IDLE);
    bidx  = {r.s2.bg, r.s2.ba};
  end

  assign all_idle = &bank_idle;
  assign ref_go   = take && c_ref;

  // ----------------------------------------
  // Bank trackers
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NBANK; gi++) begin : g_bank
      assign sel[gi] = (bidx == 4'(gi));
      dpr_bank #(
        .RP_CYC    (RP_CYC),
        .RD_AP_CYC (RD_AP_CYC),
        .WR_AP_CYC (WR_AP_CYC)
      ) u_bank (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .clk_en    (clk_en),
        .act       (take && c_act && sel[gi]),
        .pre       (take && c_pre && (sel[gi] || r.s2.a10)),
        .rd        (take && c_rd && sel[gi]),
        .wr        (take && c_wr && sel[gi]),
        .ap        (r.s2.a10),
        .ref_force (ref_go),
        .bank_open (bank_open[gi]),
        .bank_idle (bank_idle[gi])
      );
    end
  endgenerate

  // ----------------------------------------
  // Refresh rate and skip decision
  // ----------------------------------------
  logic [1:0] rate;
  logic       rsvd_mode;
  logic       skip;
  logic [9:0] rfc_load;

  always_comb begin
    rsvd_mode = 1'b0;
    case (r.ctrl.rmode)
      `DPR_RMODE_1X:   rate = 2'h0;
      `DPR_RMODE_2X:   rate = 2'h1;
      `DPR_RMODE_4X:   rate = 2'h2;
      `DPR_RMODE_OTF2: rate = r.s2.bg[0] ? 2'h1 : 2'h0;
      `DPR_RMODE_OTF4: rate = r.s2.bg[0] ? 2'h2 : 2'h0;
      default: begin
        rate      = 2'h0;
        rsvd_mode = 1'b1;
      end
    endcase
    case (rate)
      2'h1:    rfc_load = RFC2_CYC;
      2'h2:    rfc_load = RFC4_CYC;
      default: rfc_load = RFC1_CYC;
    endcase
    // Zone 0 below 45C, zone 1 from 45C to 85C, zone 2 at 85C or above
    skip = 1'b0;
    if (r.ctrl.tempref_en) begin
      if (!r.ctrl.tempref_ext) begin
        skip = (r.ctrl.temp_zone == 2'h0) && r.gear[0];
      end else if (r.ctrl.temp_zone == 2'h1) begin
        skip = r.gear[0];
      end else if (r.ctrl.temp_zone == 2'h0) begin
        skip = (r.gear != 2'h0);
      end
    end
  end

  // ----------------------------------------
  // APB access
  // ----------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic mapped;

  always_comb begin
    wr_acc   = psel && penable && pwrite;
    rd_setup = psel && !penable;
    mapped   = (paddr == `DPR_REG_CTRL) || (paddr == `DPR_REG_STATUS) ||
               (paddr == `DPR_REG_ROWCNT) || (paddr == `DPR_REG_ERR);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [4:0] err_set;
  logic [4:0] err_clr;

  always_comb begin
    r_nxt    = r;
    r_nxt.s1 = cmd_pins;
    r_nxt.s2 = r.s1;

    // Protocol faults by the controller, kept as sticky flags
    err_set = 5'h00;
    err_set[`DPR_ERR_TRFC] = !take && c_any;
    err_set[`DPR_ERR_ACT]  = take && c_act && !(|(sel & bank_idle));
    err_set[`DPR_ERR_RDWR] = take && (c_rd || c_wr) && !(|(sel & bank_open));
    err_set[`DPR_ERR_REF]  = ref_go && !all_idle;
    err_set[`DPR_ERR_MODE] = ref_go && rsvd_mode;

    // Refresh cycle
    case (r.rf_st)
      RF_IDLE: begin
        if (ref_go) begin
          r_nxt.rf_st   = RF_BUSY;
          r_nxt.rf_cnt  = rfc_load;
          r_nxt.rf_rate = rate;
          if (r.ctrl.tempref_en) begin
            r_nxt.gear = r.gear + 2'h1;
          end
          if (skip) begin
            r_nxt.skip_ctr = r.skip_ctr + 16'h0001;
          end else begin
            // Row comes from the internal counter, never from the pins
            r_nxt.row_ctr = r.row_ctr + 16'h0001;
          end
        end
      end
      RF_BUSY: begin
        if (r.rf_cnt <= 10'h001) begin
          r_nxt.rf_st = RF_IDLE;
        end else begin
          r_nxt.rf_cnt = r.rf_cnt - 10'h001;
        end
      end
      default: begin
        r_nxt.rf_st = RF_IDLE;
      end
    endcase

    // Register writes
    err_clr = 5'h00;
    if (wr_acc) begin
      if (paddr == `DPR_REG_CTRL) begin
        r_nxt.ctrl = pwdata[6:0];
      end
      if (paddr == `DPR_REG_ERR) begin
        err_clr = pwdata[4:0];
      end
    end
    // A fault landing with its clear is kept
    r_nxt.err = (r.err & ~err_clr) | err_set;

    // Read data staged in setup, shown in access
    if (rd_setup) begin
      r_nxt.pslverr = !mapped;
      r_nxt.prdata  = 32'h0000_0000;
      case (paddr)
        `DPR_REG_CTRL:   r_nxt.prdata[6:0] = r.ctrl;
        `DPR_REG_STATUS: begin
          r_nxt.prdata[`DPR_ST_BUSY]                     = (r.rf_st == RF_BUSY);
          r_nxt.prdata[`DPR_ST_RATE_LSB +: 2]            = r.rf_rate;
          r_nxt.prdata[`DPR_ST_RSVD]                     = rsvd_mode;
          r_nxt.prdata[`DPR_ST_OPEN_LSB +: 16]           = 16'(bank_open);
        end
        `DPR_REG_ROWCNT: r_nxt.prdata = {r.skip_ctr, r.row_ctr};
        `DPR_REG_ERR:    r_nxt.prdata[4:0] = r.err;
        default:         r_nxt.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      r <= '{s1: 10'h3FF, s2: 10'h3FF, ctrl: `DPR_CTRL_RST, err: `DPR_ERR_RST,
             rf_st: RF_IDLE, rf_cnt: 10'h000, rf_rate: 2'h0, row_ctr: 16'h0000,
             skip_ctr: 16'h0000, gear: 2'h0, prdata: 32'h0000_0000, pslverr: 1'b0};
    end else if (clk_en) begin
      r <= r_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ready follows the enable so no write is lost while state is frozen
  assign pready       = clk_en;
  assign prdata       = r.prdata;
  assign pslverr      = r.pslverr && psel && penable;
  assign refresh_busy = (r.rf_st == RF_BUSY);
  assign refresh_row  = r.row_ctr;

endmodule

// ---- tb/dpr_core_asserts.sv ----
// Checker for the precharge and refresh core: bank and refresh timing.
// Assumes commands at least five cycles apart, as the bench sends them.
`timescale 1ns/1ps
module dpr_core_asserts import dpr_pkg::*; #(
  parameter int NBANK = 16
) (
  // Clocking
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             clk_en,
  // Watched ports
  input wire dpr_cmd_t         cmd_pins,
  input wire logic [NBANK-1:0] bank_open,
  input wire logic             refresh_busy,
  input wire logic [15:0]      refresh_row
);
  logic       live;
  logic [3:0] op;
  logic [3:0] idx;
  logic [3:0] last_b;
  logic       last_a;
  logic [3:0] ap_b;
  logic       is_rda;
  logic       is_wra;

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  // Commands during refresh are refused, so they are not tracked
  assign live   = !cmd_pins.cs_n && clk_en && !refresh_busy;
  assign op     = {cmd_pins.act_n, cmd_pins.ras_n, cmd_pins.cas_n, cmd_pins.we_n};
  assign idx    = {cmd_pins.bg, cmd_pins.ba};
  assign is_rda = live && op == 4'hD && cmd_pins.a10;
  assign is_wra = live && op == 4'hC && cmd_pins.a10;

  always_ff @(posedge clock) begin
    if (live) begin
      last_b <= idx;
      last_a <= cmd_pins.a10;
    end
    if (is_rda || is_wra) begin
      ap_b <= idx;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  property p_act;
    live && !op[3] |-> ##[2:4] bank_open[last_b];
  endproperty
  a_act: assert property (p_act) else $error("bank not opened");
  property p_pre;
    live && op == 4'hA |-> ##[2:4] (last_a ? bank_open == '0 : !bank_open[last_b]);
  endproperty
  a_pre: assert property (p_pre) else $error("bank not closed");
  property p_rda;
    is_rda |-> ##2 bank_open[ap_b] ##[1:10] !bank_open[ap_b];
  endproperty
  a_rda: assert property (p_rda) else $error("read autoclose wrong");
  property p_wra;
    is_wra |-> ##12 bank_open[ap_b] ##[1:20] !bank_open[ap_b];
  endproperty
  a_wra: assert property (p_wra) else $error("write autoclose wrong");
  property p_ref;
    live && op == 4'h9 |-> ##[2:4] refresh_busy;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh not started");
  property p_rfc;
    $rose(refresh_busy) |-> refresh_busy [*8];
  endproperty
  a_rfc: assert property (p_rfc) else $error("refresh too short");
  property p_idle;
    $fell(refresh_busy) |-> bank_open == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("bank open after refresh");
  property p_row;
    refresh_row != $past(refresh_row) |-> $rose(refresh_busy);
  endproperty
  a_row: assert property (p_row) else $error("row moved outside refresh");
endmodule

bind dpr_core dpr_core_asserts #(.NBANK(NBANK)) dpr_core_asserts_inst (
  .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .cmd_pins(cmd_pins),
  .bank_open(bank_open), .refresh_busy(refresh_busy), .refresh_row(refresh_row));

// ---- tb/dpr_ctl_model.sv ----
// Memory controller stand-in driving the command pins.
// Assumes the bench calls send from one process only.
`timescale 1ns/1ps
module dpr_ctl_model import dpr_pkg::*; (
  // Clocking and status
  input  wire logic clock,
  input  wire logic refresh_busy,
  // Command pins
  output dpr_cmd_t  cmd_pins
);
  initial cmd_pins = 10'h3FF;

  task automatic send(input dpr_cmd_t c, input logic polite);
    int i;
    i = 0;
    while (polite && refresh_busy && i < 100) begin
      @(posedge clock);
      i++;
    end
    if (i >= 100) begin
      testbench.error_cnt++;
    end
    @(posedge clock);
    cmd_pins <= c;
    @(posedge clock);
    // Address flipped on deselect so stale pins are never trusted
    cmd_pins <= {1'b1, ~c[8:0]};
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the precharge and refresh core.
// Assumes default timing parameters and a 50 MHz clock.
`timescale 1ns/1ps
module testbench import dpr_pkg::*;;
  localparam logic [3:0] op_act = 4'h7;
  localparam logic [3:0] op_pre = 4'hA;
  localparam logic [3:0] op_rd  = 4'hD;
  localparam logic [3:0] op_wr  = 4'hC;
  localparam logic [3:0] op_ref = 4'h9;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] bank_open;
  logic        refresh_busy;
  logic [15:0] refresh_row;
  dpr_cmd_t    cmd_pins;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [31:0] rd;
  logic        er;
  logic [15:0] rows = 16'h0;
  logic [2:0]  md_t [7] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h5, 3'h6, 3'h6};
  logic [6:0]  bg_v = 7'h50;
  int          ln_t [7] = '{18, 13, 8, 18, 13, 18, 8};
  logic [1:0]  rt_t [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h0, 2'h2};

  always #10 clock = ~clock;

  dpr_core dpr_core_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .cmd_pins(cmd_pins), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank_open(bank_open), .refresh_busy(refresh_busy), .refresh_row(refresh_row));
  dpr_ctl_model dpr_ctl_model_inst (.clock(clock), .refresh_busy(refresh_busy),
    .cmd_pins(cmd_pins));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      error_cnt++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic dpr_cmd_t mk(input logic [3:0] op, input logic a10, input logic [3:0] b);
    return {1'b0, op, a10, b};
  endfunction
  task automatic go(input logic [3:0] op, input logic a10, input logic [3:0] b);
    dpr_ctl_model_inst.send(mk(op, a10, b), 1'b1);
    wt(4);
  endtask
  // Refresh then timed wait; the busy flag rises even on skipped ones
  task automatic ref_raw();
    dpr_ctl_model_inst.send(mk(op_ref, 1'b0, 4'h0), 1'b1);
    wt(30);
  endtask
  task automatic do_ref(input logic bg0, input int len);
    int i;
    int n;
    i = 0;
    n = 0;
    dpr_ctl_model_inst.send(mk(op_ref, 1'b0, {1'b0, bg0, 2'b00}), 1'b1);
    while (!refresh_busy && i < 10) begin
      @(posedge clock);
      i++;
    end
    while (refresh_busy && n < 40) begin
      @(posedge clock);
      n++;
    end
    rows++;
    chk("refresh_len", 32'(n), 32'(len));
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    wt(20);
    sys_rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      chk("reg_reset", rd, 32'h0);
    end
    apb(1'b1, 8'h10, 32'hFFFFFFFF);
    chk("unmapped", 32'(er), 32'h1);
    go(op_act, 1'b0, 4'h5);
    go(op_act, 1'b0, 4'h9);
    chk("act", 32'(bank_open), 32'h220);
    go(op_pre, 1'b0, 4'h5);
    chk("pre_one", 32'(bank_open), 32'h200);
    go(op_pre, 1'b0, 4'h5);
    apb(1'b0, 8'h0C, 32'h0);
    chk("pre_idle", rd, 32'h0);
    go(op_act, 1'b0, 4'h3);
    go(op_wr, 1'b1, 4'h3);
    go(op_rd, 1'b0, 4'h9);
    chk("wr_hold", 32'(bank_open), 32'h208);
    wt(30);
    chk("wr_ap", 32'(bank_open), 32'h200);
    go(op_rd, 1'b1, 4'h9);
    wt(12);
    chk("rd_ap", 32'(bank_open), 32'h0);
    go(op_rd, 1'b0, 4'h9);
    apb(1'b0, 8'h0C, 32'h0);
    chk("rd_idle", rd, 32'h4);
    apb(1'b1, 8'h0C, 32'h1F);
    go(op_act, 1'b0, 4'h1);
    go(op_act, 1'b0, 4'h2);
    go(op_pre, 1'b1, 4'h0);
    chk("pre_all", 32'(bank_open), 32'h0);
    go(op_act, 1'b0, 4'h6);
    do_ref(1'b0, 18);
    chk("ref_idle", 32'(bank_open), 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("ref_open", rd, 32'h8);
    dpr_ctl_model_inst.send(mk(op_ref, 1'b0, 4'h0), 1'b1);
    wt(3);
    dpr_ctl_model_inst.send(mk(op_act, 1'b0, 4'h7), 1'b0);
    wt(30);
    rows++;
    chk("busy_cmd", 32'(bank_open), 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk("busy_err", rd, 32'h9);
    for (int k = 0; k < 7; k++) begin
      apb(1'b1, 8'h00, {29'h0, md_t[k]});
      do_ref(bg_v[k], ln_t[k]);
      apb(1'b0, 8'h04, 32'h0);
      chk("rate", 32'(rd[2:1]), 32'(rt_t[k]));
    end
    apb(1'b0, 8'h08, 32'h0);
    chk("rows", rd, {16'h0, rows});
    chk("row_out", 32'(refresh_row), 32'(rows));
    apb(1'b1, 8'h00, 32'h8);
    ref_raw();
    ref_raw();
    apb(1'b0, 8'h08, 32'h0);
    chk("tcr_skip", rd, {16'h1, rows + 16'h1});
    apb(1'b1, 8'h00, 32'h28);
    ref_raw();
    ref_raw();
    apb(1'b0, 8'h08, 32'h0);
    chk("tcr_mid", rd, {16'h1, rows + 16'h3});
    apb(1'b1, 8'h00, 32'h18);
    repeat (4) ref_raw();
    apb(1'b0, 8'h08, 32'h0);
    chk("ext_cold", rd, {16'h4, rows + 16'h4});
    apb(1'b1, 8'h00, 32'h3);
    ref_raw();
    apb(1'b0, 8'h04, 32'h0);
    chk("rsvd_st", 32'(rd[3]), 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk("rsvd_err", 32'(rd[4]), 32'h1);
    clk_en <= 1'b0;
    @(negedge clock);
    chk("frozen", 32'(pready), 32'h0);
    @(posedge clock);
    clk_en <= 1'b1;
    wt(1);
    sys_rst <= 1'b1;
    wt(2);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk("rst_rows", rd, 32'h0);
    results();
  end
endmodule
